// [rtl/synth_regs_pkg.sv]
// package: offsets, field layout, reset values and types of the synthesizer register slice
// assumes: 32-bit apb slave, 8-bit registers in the low byte of each word
package synth_regs_pkg;
   // printed offsets are not all multiples of four: kept as indices
   localparam logic [7:0] idx_synth1_filter_r3_mode = 8'h45;
   localparam logic [7:0] idx_synth1_filter_c3 = 8'h46;
   localparam logic [7:0] idx_synth2_control_a = 8'h47;
   localparam int addr_w = 12;
   localparam logic [11:0] addr_r3_mode = {2'h0, idx_synth1_filter_r3_mode, 2'h0};
   localparam logic [11:0] addr_c3 = {2'h0, idx_synth1_filter_c3, 2'h0};
   localparam logic [11:0] addr_ctrl_a = {2'h0, idx_synth2_control_a, 2'h0};
   // field layout
   localparam int r3_code_lsb = 1;
   localparam int r3_code_msb = 6;
   localparam int frac_sel_bit = 0;
   localparam int c3_code_msb = 2;
   localparam int c3_code_lsb = 0;
   localparam int post_div_lsb = 2;
   localparam int post_div_msb = 4;
   localparam int resync_bit = 1;
   localparam int power_down_bit = 0;
   // writable masks and reset values
   localparam logic [7:0] mask_r3_mode = 8'h7f;
   localparam logic [7:0] mask_c3 = 8'h07;
   localparam logic [7:0] mask_ctrl_a = 8'h1f;
   localparam logic [7:0] reset_r3_mode = 8'h00;
   localparam logic [7:0] reset_c3 = 8'h00;
   localparam logic [7:0] reset_ctrl_a = 8'h1e;
   // post-divider code to ratio
   localparam logic [2:0] post_div_min_code = 3'h2;
   localparam logic [3:0] post_div_min_ratio = 4'h2;
   localparam logic [3:0] post_div_offset = 4'h1;
   // calibration sequence length after power-up
   localparam int cal_time_us = 10;
   localparam int clk_mhz = 10;
   localparam int cal_cycles = cal_time_us * clk_mhz;
   localparam logic [7:0] cal_done_status_bit = 8'h01;

   typedef struct packed {
      logic [5:0] r3_code;
      logic fractional;
      logic [2:0] c3_code;
   } synth1_filter_t;

   typedef struct packed {
      logic [2:0] post_div_code;
      logic [3:0] post_div_ratio;
      logic resync_enable;
      logic power_down;
   } synth2_ctrl_t;

   typedef enum logic [1:0] {
      cal_off = 2'b00,
      cal_run = 2'b01,
      cal_done = 2'b10
   } cal_state_t;
endpackage : synth_regs_pkg

// [rtl/synth2_cal_seq.sv]
// synth2 enable and calibration sequencer
// assumes: power_down_in comes from a register on the same clock
`timescale 1ns/1ns
`default_nettype none
module synth2_cal_seq
   import synth_regs_pkg::*;
#(
   parameter int cal_len = cal_cycles
)
(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic power_down_in,
   output logic synth_enable_out,
   output logic cal_reset_out,
   output logic cal_busy_out,
   output logic cal_done_out
);
   cal_state_t state;
   cal_state_t next_state;
   logic [15:0] count;
   logic [15:0] next_count;

   always_comb
   begin
      next_state = state;
      next_count = count;
      unique case (state)
         cal_off:
         begin
            next_count = 16'h0000;
            if (!power_down_in)
            begin
               next_state = cal_run;
            end
         end
         cal_run:
         begin
            if (power_down_in)
            begin
               next_state = cal_off;
            end
            else if (count == 16'(cal_len - 1))
            begin
               next_state = cal_done;
            end
            else
            begin
               next_count = count + 16'h0001;
            end
         end
         cal_done:
         begin
            if (power_down_in)
            begin
               next_state = cal_off;
            end
         end
         default:
         begin
            next_state = cal_off;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         state <= cal_off;
         count <= 16'h0000;
      end
      else
      begin
         state <= next_state;
         count <= next_count;
      end
   end

   assign synth_enable_out = (state != cal_off);
   assign cal_reset_out = (state == cal_off);
   assign cal_busy_out = (state == cal_run);
   assign cal_done_out = (state == cal_done);
endmodule : synth2_cal_seq
`default_nettype wire

// [rtl/synth_loop_filter_postdiv_regs.sv]
// apb register slice: synth1 third-pole filter, synth2 post-divider, resync, power-down
// assumes: apb master on clk_in; analog filter, divider and sync logic outside
//
// What this block does
// - a 6-bit resistor code at bits 6..1, reset zero, selects the third-pole resistor.
// - bit 0 of the resistor register picks integer (0) or fractional (1) filter, reset 0.
// - a 3-bit capacitor code at bits 2..0, reset zero, gives five pF per step.
// - bits 4..2 set the synth2 post-divider, reset 7; codes 0,1 give 2, 2..7 give 3..8.
// - bit 1, reset 1, lets a sync event resync every channel fed by synth2.
// - bit 0, reset 0, decides whether synth2 comes up enabled and calibrated after reset.
// - writing power-down to 1 disables synth2 and holds its calibration in reset.
// - clearing power-down re-enables synth2 and starts calibration on its own.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module synth_loop_filter_postdiv_regs
   import synth_regs_pkg::*;
#(
   parameter int cal_len = cal_cycles
)
(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [addr_w-1:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [3:0] pstrb_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic sync_event_in,
   output synth1_filter_t synth1_filter_out,
   output synth2_ctrl_t synth2_ctrl_out,
   output logic synth2_resync_out,
   output logic synth2_enable_out,
   output logic synth2_cal_reset_out,
   output logic synth2_cal_busy_out
);
   logic [7:0] r3_mode;
   logic [7:0] c3;
   logic [7:0] ctrl_a;
   logic [7:0] next_r3_mode;
   logic [7:0] next_c3;
   logic [7:0] next_ctrl_a;
   logic [31:0] next_prdata;
   logic next_pslverr;
   logic [31:0] prdata;
   logic pslverr;
   logic sync_meta;
   logic sync_sync;
   logic sync_prev;
   logic resync;
   logic next_resync;
   logic cal_complete;
   logic [15:0] busy_cycles;
   logic [15:0] next_busy_cycles;

   function automatic logic [3:0] post_div_ratio(input logic [2:0] code);
      if (code < post_div_min_code)
      begin
         return post_div_min_ratio;
      end
      return 4'(code) + post_div_offset;
   endfunction : post_div_ratio

   function automatic logic known_addr(input logic [addr_w-1:0] a);
      return (a == addr_r3_mode) || (a == addr_c3) || (a == addr_ctrl_a);
   endfunction : known_addr

   wire logic access = psel_in && penable_in;
   wire logic wr_ok = access && pwrite_in && pstrb_in[0];

   // register writes; reserved bits masked off
   always_comb
   begin
      next_r3_mode = r3_mode;
      next_c3 = c3;
      next_ctrl_a = ctrl_a;
      if (wr_ok)
      begin
         unique case (paddr_in)
            addr_r3_mode: next_r3_mode = pwdata_in[7:0] & mask_r3_mode;
            addr_c3: next_c3 = pwdata_in[7:0] & mask_c3;
            addr_ctrl_a: next_ctrl_a = pwdata_in[7:0] & mask_ctrl_a;
            default: next_r3_mode = r3_mode;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         r3_mode <= reset_r3_mode;
         c3 <= reset_c3;
         ctrl_a <= reset_ctrl_a;
      end
      else
      begin
         r3_mode <= next_r3_mode;
         c3 <= next_c3;
         ctrl_a <= next_ctrl_a;
      end
   end

   // read data registered on the setup cycle, valid in access phase
   always_comb
   begin
      next_prdata = 32'h0000_0000;
      next_pslverr = 1'b0;
      if (psel_in && !penable_in)
      begin
         next_pslverr = !known_addr(paddr_in);
         if (!pwrite_in)
         begin
            unique case (paddr_in)
               addr_r3_mode: next_prdata = {24'h00_0000, r3_mode};
               addr_c3: next_prdata = {24'h00_0000, c3};
               addr_ctrl_a: next_prdata = {24'h00_0000, ctrl_a};
               default: next_prdata = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         prdata <= next_prdata;
         pslverr <= next_pslverr;
      end
   end

   assign prdata_out = prdata;
   assign pready_out = 1'b1;
   assign pslverr_out = pslverr && access;

   // sync event from a pin: two flops then edge detect
   always_comb
   begin
      next_resync = sync_sync && !sync_prev && ctrl_a[resync_bit];
   end

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         sync_meta <= 1'b0;
         sync_sync <= 1'b0;
         sync_prev <= 1'b0;
         resync <= 1'b0;
      end
      else
      begin
         sync_meta <= sync_event_in;
         sync_sync <= sync_meta;
         sync_prev <= sync_sync;
         resync <= next_resync;
      end
   end

   assign synth2_resync_out = resync;

   assign synth1_filter_out.r3_code = r3_mode[r3_code_msb:r3_code_lsb];
   assign synth1_filter_out.fractional = r3_mode[frac_sel_bit];
   assign synth1_filter_out.c3_code = c3[c3_code_msb:c3_code_lsb];
   assign synth2_ctrl_out.post_div_code = ctrl_a[post_div_msb:post_div_lsb];
   assign synth2_ctrl_out.post_div_ratio =
      post_div_ratio(ctrl_a[post_div_msb:post_div_lsb]);
   assign synth2_ctrl_out.resync_enable = ctrl_a[resync_bit];
   assign synth2_ctrl_out.power_down = ctrl_a[power_down_bit];

   // power-down bit drives enable/calibration; reset value 0 starts cal after reset
   synth2_cal_seq #(
      .cal_len(cal_len)
   ) cal_seq (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .power_down_in(ctrl_a[power_down_bit]),
      .synth_enable_out(synth2_enable_out),
      .cal_reset_out(synth2_cal_reset_out),
      .cal_busy_out(synth2_cal_busy_out),
      .cal_done_out(cal_complete)
   );

   // run length of the current calibration, for the checks below
   always_comb
   begin
      next_busy_cycles = synth2_cal_busy_out ? busy_cycles + 16'h0001 : 16'h0000;
   end

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         busy_cycles <= 16'h0000;
      end
      else
      begin
         busy_cycles <= next_busy_cycles;
      end
   end

   // register contents and bus answers
   a_reserved_zero: assert property (@(posedge clk_in) disable iff (!resetn_in)
      ((r3_mode & ~mask_r3_mode) == 8'h00) && ((c3 & ~mask_c3) == 8'h00)
      && ((ctrl_a & ~mask_ctrl_a) == 8'h00))
      else $error("reserved bit stored");
   a_write_r3: assert property (@(posedge clk_in) disable iff (!resetn_in)
      wr_ok && paddr_in == addr_r3_mode |=> synth1_filter_out.r3_code
      == $past(pwdata_in[r3_code_msb:r3_code_lsb])
      && synth1_filter_out.fractional == $past(pwdata_in[frac_sel_bit]))
      else $error("resistor/mode write lost");
   a_frac_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
      !(wr_ok && paddr_in == addr_r3_mode) |=> $stable(synth1_filter_out.fractional))
      else $error("filter mode changed without write");
   a_r3_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
      !(wr_ok && paddr_in == addr_r3_mode) |=> $stable(synth1_filter_out.r3_code))
      else $error("resistor code changed without write");
   a_write_c3: assert property (@(posedge clk_in) disable iff (!resetn_in)
      wr_ok && paddr_in == addr_c3 |=> synth1_filter_out.c3_code
      == $past(pwdata_in[c3_code_msb:c3_code_lsb]))
      else $error("capacitor write lost");
   a_c3_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
      !(wr_ok && paddr_in == addr_c3) |=> $stable(synth1_filter_out.c3_code))
      else $error("capacitor code changed without write");
   a_write_ctrl: assert property (@(posedge clk_in) disable iff (!resetn_in)
      wr_ok && paddr_in == addr_ctrl_a |=> synth2_ctrl_out.post_div_code
      == $past(pwdata_in[post_div_msb:post_div_lsb])
      && synth2_ctrl_out.resync_enable == $past(pwdata_in[resync_bit])
      && synth2_ctrl_out.power_down == $past(pwdata_in[power_down_bit]))
      else $error("control write lost");
   a_ctrl_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
      !(wr_ok && paddr_in == addr_ctrl_a) |=> $stable(synth2_ctrl_out))
      else $error("control changed without write");
   a_post_div: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (synth2_ctrl_out.post_div_code <= 3'h1) ? synth2_ctrl_out.post_div_ratio == 4'h2
      : synth2_ctrl_out.post_div_ratio == 4'(synth2_ctrl_out.post_div_code) + 4'h1)
      else $error("post-divider ratio wrong");
   a_strobe_block: assert property (@(posedge clk_in) disable iff (!resetn_in)
      access && pwrite_in && !pstrb_in[0] |=> $stable(r3_mode) && $stable(c3) && $stable(ctrl_a))
      else $error("write without strobe stored");
   a_unmapped_write: assert property (@(posedge clk_in) disable iff (!resetn_in)
      access && pwrite_in && !known_addr(paddr_in) |=> $stable({r3_mode, c3, ctrl_a}))
      else $error("unmapped write stored");
   a_bad_addr_err: assert property (@(posedge clk_in) disable iff (!resetn_in)
      access && $past(psel_in && !penable_in) && $stable(paddr_in) && !known_addr(paddr_in)
      |-> pslverr_out) else $error("unmapped access not flagged");
   a_err_mapped: assert property (@(posedge clk_in) disable iff (!resetn_in)
      access && $past(psel_in && !penable_in) && $stable(paddr_in) && known_addr(paddr_in)
      |-> !pslverr_out) else $error("mapped access flagged");
   a_read_c3: assert property (@(posedge clk_in) disable iff (!resetn_in)
      access && !pwrite_in && paddr_in == addr_c3 && $past(psel_in && !penable_in)
      |-> prdata_out == 32'(synth1_filter_out.c3_code)) else $error("capacitor read wrong");

   // sync handling
   a_resync_gate: assert property (@(posedge clk_in) disable iff (!resetn_in)
      synth2_resync_out |-> $past(ctrl_a[resync_bit])
      && $past(sync_sync) && !$past(sync_prev))
      else $error("resync without enable or edge");
   a_resync_pulse: assert property (@(posedge clk_in) disable iff (!resetn_in)
      synth2_resync_out |=> !synth2_resync_out)
      else $error("resync pulse too long");
   a_resync_disabled: assert property (@(posedge clk_in) disable iff (!resetn_in)
      !ctrl_a[resync_bit] |=> !synth2_resync_out)
      else $error("resync while disabled");

   // power-down and calibration
   a_pdn_off: assert property (@(posedge clk_in) disable iff (!resetn_in)
      ctrl_a[power_down_bit] |=> !synth2_enable_out && synth2_cal_reset_out)
      else $error("synth2 not held off");
   a_pdn_cal_start: assert property (@(posedge clk_in) disable iff (!resetn_in)
      $fell(ctrl_a[power_down_bit]) |-> ##1 synth2_cal_busy_out ##1 synth2_enable_out)
      else $error("calibration not started");
   a_reset_cal: assert property (@(posedge clk_in) disable iff (!resetn_in)
      $rose(resetn_in) ##0 !ctrl_a[power_down_bit] |=> synth2_cal_busy_out)
      else $error("no calibration after reset");
   a_enable_vs_reset: assert property (@(posedge clk_in) disable iff (!resetn_in)
      synth2_enable_out != synth2_cal_reset_out)
      else $error("enable and calibration reset overlap");
   a_busy_enabled: assert property (@(posedge clk_in) disable iff (!resetn_in)
      synth2_cal_busy_out |-> synth2_enable_out)
      else $error("calibration while disabled");
   a_cal_length: assert property (@(posedge clk_in) disable iff (!resetn_in)
      synth2_cal_busy_out |-> busy_cycles < 16'(cal_len))
      else $error("calibration too long");
   a_cal_complete: assert property (@(posedge clk_in) disable iff (!resetn_in)
      $fell(synth2_cal_busy_out) && synth2_enable_out |-> $past(busy_cycles) == 16'(cal_len - 1))
      else $error("calibration ended early");

   c_cal_done: cover property (@(posedge clk_in) disable iff (!resetn_in) $rose(cal_complete));
   c_resync: cover property (@(posedge clk_in) disable iff (!resetn_in) synth2_resync_out);
   c_power_down: cover property (@(posedge clk_in) disable iff (!resetn_in)
      $rose(ctrl_a[power_down_bit]));
   c_bad_addr: cover property (@(posedge clk_in) disable iff (!resetn_in) pslverr_out);
   c_cal_abort: cover property (@(posedge clk_in) disable iff (!resetn_in)
      synth2_cal_busy_out && ctrl_a[power_down_bit]);
endmodule : synth_loop_filter_postdiv_regs
`default_nettype wire

// [sim/synth_loop_filter_postdiv_regs_tb.sv]
// testbench: apb register slice for synth1 filter and synth2 control
// assumes: zero wait-state apb slave, short calibration parameter
`timescale 1ns/1ns
`default_nettype none
module synth_loop_filter_postdiv_regs_tb;
   import synth_regs_pkg::*;
   localparam int cal_len_tb = 4;
   logic clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic sync_ev = 1'b0;
   logic [addr_w-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0] pstrb = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   synth1_filter_t f1;
   synth2_ctrl_t c2;
   logic resync;
   logic en;
   logic cal_rst;
   logic busy;
   int errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [32:0] exp_q[$];

   synth_loop_filter_postdiv_regs #(.cal_len(cal_len_tb)) synth_loop_filter_postdiv_regs_i (
      .clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .sync_event_in(sync_ev), .synth1_filter_out(f1), .synth2_ctrl_out(c2),
      .synth2_resync_out(resync), .synth2_enable_out(en),
      .synth2_cal_reset_out(cal_rst), .synth2_cal_busy_out(busy));

   initial
   begin
      forever #50 clk_in = ~clk_in;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   task give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict

   // each transfer notes {error, read data} before it starts
   task apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [3:0] s,
            input logic [32:0] e);
      @(posedge clk_in);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      exp_q.push_back(e);
      @(posedge clk_in);
      penable <= 1'b1;
      do
      begin
         @(posedge clk_in);
      end
      while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(a, 1'b1, d, 4'h1, 33'h0_0000_0000);
   endtask : wr

   task rd(input logic [11:0] a, input logic [31:0] e);
      apb(a, 1'b0, 32'h0000_0000, 4'h0, {1'b0, e});
   endtask : rd

   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         errors++;
         $display("Error at %0t: timeout", $time);
         give_verdict();
      end
   end

   // completion monitor: takes the oldest note at each finished transfer
   always @(posedge clk_in)
   begin
      logic [32:0] e;
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
      begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1_ffff_ffff;
         if (pwrite !== 1'b1)
            check(prdata, e[31:0], "read data");
         check({31'h0, pslverr}, {31'h0, e[32]}, "error flag");
      end
   end

   initial
   begin
      logic [31:0] v;
      logic [2:0] c;
      logic [7:0] last_c3;
      logic [6:0] last_r3;
      int cnt;
      void'($urandom(32'haae6c25c));
      repeat (4) @(posedge clk_in);
      resetn_in <= 1'b1;
      rd(addr_r3_mode, 32'h0000_0000);
      rd(addr_c3, 32'h0000_0000);
      rd(addr_ctrl_a, 32'h0000_001e);
      @(negedge clk_in);
      check(32'(c2.post_div_ratio), 32'h0000_0008, "reset ratio");
      check(32'(c2.resync_enable), 32'h0000_0001, "reset resync");
      check(32'(en), 32'h0000_0001, "enabled after reset");
      check(32'(cal_rst), 32'h0000_0000, "cal reset after reset");
      $display("test reset values done");
      for (int i = 0; i < 4; i++)
      begin
         v = $urandom;
         last_r3 = v[6:0];
         wr(addr_r3_mode, v);
         rd(addr_r3_mode, {25'h0, last_r3});
         @(negedge clk_in);
         check(32'(f1.r3_code), 32'(v[6:1]), "resistor code");
         check(32'(f1.fractional), 32'(v[0]), "fractional select");
         v = $urandom;
         last_c3 = {5'h0, v[2:0]};
         wr(addr_c3, v);
         rd(addr_c3, {24'h0, last_c3});
         @(negedge clk_in);
         check(32'(f1.c3_code), 32'(v[2:0]), "capacitor code");
      end
      $display("test filter fields done");
      for (int i = 0; i < 8; i++)
      begin
         v = $urandom;
         c = 3'(i);
         wr(addr_ctrl_a, {v[31:5], c, 2'b10});
         rd(addr_ctrl_a, {27'h0, c, 2'b10});
         @(negedge clk_in);
         check(32'(c2.post_div_ratio), (i < 2) ? 32'h2 : 32'(i + 1), "post ratio");
         check(32'(c2.post_div_code), 32'(c), "post code");
         check(32'(c2.power_down), 32'h0, "power-down field");
      end
      $display("test post divider done");
      apb(addr_c3, 1'b1, 32'h0000_0005, 4'h0, 33'h0_0000_0000);
      rd(addr_c3, {24'h0, last_c3});
      apb(12'h120, 1'b0, 32'h0000_0000, 4'h0, 33'h1_0000_0000);
      apb(12'h110, 1'b1, 32'h0000_00ff, 4'h1, 33'h1_0000_0000);
      rd(addr_r3_mode, {25'h0, last_r3});
      $display("test refusals done");
      for (int k = 0; k < 2; k++)
      begin
         wr(addr_ctrl_a, k ? 32'h0000_001e : 32'h0000_001c);
         @(posedge clk_in);
         sync_ev <= 1'b1;
         cnt = 0;
         repeat (8)
         begin
            @(negedge clk_in);
            if (resync === 1'b1)
               cnt++;
         end
         @(posedge clk_in);
         sync_ev <= 1'b0;
         check(32'(cnt), 32'(k), "resync pulses");
      end
      $display("test resync done");
      wr(addr_ctrl_a, 32'h0000_001f);
      repeat (2) @(negedge clk_in);
      check(32'(en), 32'h0, "enable in power down");
      check(32'(cal_rst), 32'h1, "cal reset in power down");
      check(32'(c2.power_down), 32'h1, "power-down field set");
      wr(addr_ctrl_a, 32'h0000_001e);
      cnt = 0;
      repeat (cal_len_tb + 4)
      begin
         @(negedge clk_in);
         if (busy === 1'b1)
            cnt++;
      end
      check(32'(cnt), 32'(cal_len_tb), "calibration length");
      check(32'(en), 32'h1, "enable after power up");
      check(32'(cal_rst), 32'h0, "cal reset released");
      wr(addr_ctrl_a, 32'h0000_001f);
      wr(addr_ctrl_a, 32'h0000_001e);
      wr(addr_ctrl_a, 32'h0000_001f);
      repeat (2) @(negedge clk_in);
      check({30'h0, busy, en}, 32'h0, "abort calibration");
      $display("test power down done");
      @(posedge clk_in);
      resetn_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      resetn_in <= 1'b1;
      cnt = 0;
      repeat (cal_len_tb + 4)
      begin
         @(negedge clk_in);
         if (busy === 1'b1)
            cnt++;
      end
      check(32'(cnt), 32'(cal_len_tb), "calibration after reset");
      check(32'(en), 32'h1, "enabled after reset");
      rd(addr_ctrl_a, 32'h0000_001e);
      $display("test mid-run reset done");
      give_verdict();
   end
endmodule : synth_loop_filter_postdiv_regs_tb
`default_nettype wire
